// file: hdl/ced_dispatch.sv
// exception detection, prioritisation and dispatch
`timescale 1ns/1ps
// Summary of operation
// RL1: on any exception flush faulting and in-flight instructions, fetch at handler vector
// RL2: taking an exception switches privilege to kernel mode
// RL3: resume address is faulting pc, or preceding branch pc for delay slot
// RL4: set delay-slot flag in cause bit 31 when resume address corrected
// RL5: write five-bit cause code into cause bits 6 down to 2
// RL6: reset exception on reset release, vector 0xbfc00000 regardless of boot select
// RL7: nmi on falling edge of nmi pin; reset and nmi leave code unchanged
// RL8: bus error pin gives code 6 for fetch, 7 for data access
// RL9: misaligned word/half or user kernel-segment access: code 4 load/fetch, 5 store
// RL10: trapping add/sub overflow raises code 12
// RL11: service trap instruction raises code 8
// RL12: break instruction raises code 9
// RL13: reserved opcode raises code 10
// RL14: coprocessor instruction with usability bit clear raises code 11
// RL15: pending interrupt raises code 0
// RL16: protection circuit request: code 2 load/fetch, 3 store, general vector
// RL17: user map miss vectors 0x80000000, or 0xbfc00100 under boot select
// RL18: boot select set uses alternate set, general vector 0xbfc00180
// RL19: debug exceptions vector 0xbfc00200, no cause code, cause in debug reg
// RL20: other coded exceptions share the general vector
// RL21: map-modified code 1 is never generated
module ced_dispatch #(
    parameter int AW = ced_pkg::XLEN
) (
    input  wire logic          clock,
    input  wire logic          nrst,
    // asynchronous pins
    input  wire logic          nmi_n_pin,
    input  wire logic          bus_error_pin,
    // pipeline, exception stage
    input  wire logic          stage_valid,
    input  wire logic [AW-1:0] stage_pc,
    input  wire logic          stage_in_delay_slot,
    input  wire logic          stage_is_fetch_fault,
    input  wire logic          mem_access,
    input  wire logic          mem_store,
    input  wire logic [1:0]    mem_size,
    input  wire logic [AW-1:0] mem_addr,
    input  wire logic          fetch_misaligned,
    input  wire logic          trap_overflow,
    input  wire logic          service_trap_instr,
    input  wire logic          break_instr,
    input  wire logic          reserved_opcode,
    input  wire logic          coproc_instr,
    input  wire logic [1:0]    coproc_unit,
    input  wire logic          irq_pending,
    input  wire logic          protect_req,
    input  wire logic          user_map_miss,
    input  wire logic          debug_step,
    input  wire logic          debug_break,
    input  wire logic          return_from_exc,
    // status bits
    input  wire logic          boot_vector_select,
    input  wire logic [3:0]    coproc_usable_bits,
    // outputs
    output logic               flush,
    output logic               fetch_redirect,
    output logic [AW-1:0]      fetch_target,
    output logic               kernel_mode,
    output logic [AW-1:0]      resume_pc_reg,
    output logic               delay_slot_flag,
    output logic [4:0]         cause_code_field,
    output logic [1:0]         coproc_error_unit,
    output logic [31:0]        cause_reg,
    output logic [1:0]         debug_cause,
    output logic               debug_taken
);
    logic nmi_act_s;
    logic nmi_n_s;
    logic bus_err_s;

    // nmi inverted before the flops so their reset value is its idle level
    ced_sync #(.W(2)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .din   ({~nmi_n_pin, bus_error_pin}),
        .dout  ({nmi_act_s, bus_err_s})
    );

    assign nmi_n_s = ~nmi_act_s;

    // state
    logic               nmi_n_prev_q, nmi_n_prev_d;
    logic               rst_pend_q,   rst_pend_d;
    logic               nmi_pend_q,   nmi_pend_d;
    logic               flush_q,      flush_d;
    logic               redir_q,      redir_d;
    logic [AW-1:0]      target_q,     target_d;
    logic               kernel_q,     kernel_d;
    logic [AW-1:0]      epc_q,        epc_d;
    logic               bd_q,         bd_d;
    logic [4:0]         code_q,       code_d;
    logic [1:0]         ce_q,         ce_d;
    logic [1:0]         dbg_q,        dbg_d;
    logic               dbg_tk_q,     dbg_tk_d;

    logic               misalign;
    logic               pc_viol;
    logic               priv_viol;
    logic               addr_err;
    logic               cp_unusable;
    ced_pkg::ced_kind_t kind;
    logic [4:0]         code_sel;
    logic [AW-1:0]      vec_sel;

    always_comb begin
        misalign = 1'b0;
        if (mem_access) begin
            case (mem_size)
                ced_pkg::SIZE_WORD: misalign = |mem_addr[1:0];
                ced_pkg::SIZE_HALF: misalign = mem_addr[0];
                default:            misalign = 1'b0;
            endcase
        end
        // user mode may not reach kernel segments
        pc_viol     = !kernel_q && stage_pc[AW-1]; // [RL9]
        priv_viol   = (!kernel_q && mem_access && mem_addr[AW-1]) || pc_viol; // [RL9]
        addr_err    = misalign || fetch_misaligned || priv_viol; // [RL9]
        cp_unusable = coproc_instr && !coproc_usable_bits[coproc_unit]; // [RL14]
    end

    // priority selection of the exception in the stage
    always_comb begin
        kind     = ced_pkg::CED_K_NONE;
        code_sel = code_q;
        if (rst_pend_q) begin
            kind = ced_pkg::CED_K_RESET; // [RL6]
        end else if (nmi_pend_q) begin
            kind = ced_pkg::CED_K_NMI; // [RL7]
        end else if (stage_valid) begin
            kind = ced_pkg::CED_K_GENERAL; // [RL20]
            if (debug_step || debug_break) begin
                kind = ced_pkg::CED_K_DEBUG; // [RL19]
            end else if (user_map_miss) begin
                kind     = ced_pkg::CED_K_UMISS; // [RL17]
                code_sel = mem_store ? ced_pkg::MAP_MISS_STORE_CODE : ced_pkg::MAP_MISS_LOAD_CODE;
            end else if (addr_err) begin
                code_sel = (mem_access && mem_store && !fetch_misaligned && !pc_viol) ?
                           ced_pkg::MISALIGN_STORE_CODE : ced_pkg::MISALIGN_LOAD_CODE; // [RL9]
            end else if (protect_req) begin
                code_sel = mem_store ? ced_pkg::MAP_MISS_STORE_CODE : ced_pkg::MAP_MISS_LOAD_CODE; // [RL16]
            end else if (bus_err_s) begin
                code_sel = stage_is_fetch_fault ? ced_pkg::FETCH_BUS_FAULT_CODE
                                                : ced_pkg::DATA_BUS_FAULT_CODE; // [RL8]
            end else if (reserved_opcode) begin
                code_sel = ced_pkg::RESERVED_OPCODE_CODE; // [RL13]
            end else if (cp_unusable) begin
                code_sel = ced_pkg::COPROC_UNUSABLE_CODE; // [RL14]
            end else if (service_trap_instr) begin
                code_sel = ced_pkg::SERVICE_TRAP_CODE; // [RL11]
            end else if (break_instr) begin
                code_sel = ced_pkg::TRAP_BREAK_CODE; // [RL12]
            end else if (trap_overflow) begin
                code_sel = ced_pkg::ARITH_OVERFLOW_CODE; // [RL10]
            end else if (irq_pending) begin
                code_sel = ced_pkg::INT_CODE; // [RL15]
            end else begin
                kind = ced_pkg::CED_K_NONE;
            end
        end
    end

    // vector selection; map-modified code is never produced [RL21]
    always_comb begin
        case (kind)
            ced_pkg::CED_K_RESET,
            ced_pkg::CED_K_NMI:   vec_sel = ced_pkg::VEC_RESET; // [RL6]
            ced_pkg::CED_K_DEBUG: vec_sel = ced_pkg::VEC_DEBUG; // [RL19]
            ced_pkg::CED_K_UMISS: vec_sel = boot_vector_select ? ced_pkg::VEC_USER_MISS_BOOT
                                                               : ced_pkg::VEC_USER_MISS; // [RL17]
            ced_pkg::CED_K_GENERAL: vec_sel = boot_vector_select ? ced_pkg::VEC_GENERAL_BOOT
                                                                 : ced_pkg::VEC_GENERAL; // [RL18] [RL16]
            default:              vec_sel = target_q;
        endcase
    end

    always_comb begin
        nmi_n_prev_d = nmi_n_s;
        rst_pend_d   = 1'b0;
        nmi_pend_d   = nmi_pend_q || (nmi_n_prev_q && !nmi_n_s); // [RL7]
        flush_d      = 1'b0;
        redir_d      = 1'b0;
        target_d     = target_q;
        kernel_d     = return_from_exc ? 1'b0 : kernel_q;
        epc_d        = epc_q;
        bd_d         = bd_q;
        code_d       = code_q;
        ce_d         = ce_q;
        dbg_d        = dbg_q;
        dbg_tk_d     = 1'b0;
        if (kind != ced_pkg::CED_K_NONE) begin
            flush_d  = 1'b1; // [RL1]
            redir_d  = 1'b1; // [RL1]
            target_d = vec_sel; // [RL1]
            kernel_d = 1'b1; // [RL2]
            if (kind == ced_pkg::CED_K_NMI) begin
                // a new edge in the taking cycle stays pending
                nmi_pend_d = nmi_n_prev_q && !nmi_n_s; // [RL7]
            end
            if (kind != ced_pkg::CED_K_RESET && kind != ced_pkg::CED_K_NMI) begin
                epc_d = stage_in_delay_slot ? stage_pc - ced_pkg::BRANCH_STEP : stage_pc; // [RL3]
                bd_d  = stage_in_delay_slot; // [RL4]
            end
            if (kind == ced_pkg::CED_K_DEBUG) begin
                dbg_d    = {debug_break, debug_step}; // [RL19]
                dbg_tk_d = 1'b1;
            end else if (kind == ced_pkg::CED_K_UMISS || kind == ced_pkg::CED_K_GENERAL) begin
                code_d = code_sel; // [RL5]
                if (code_sel == ced_pkg::COPROC_UNUSABLE_CODE) begin
                    ce_d = coproc_unit;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            nmi_n_prev_q <= 1'b1;
            rst_pend_q   <= 1'b1; // [RL6]
            nmi_pend_q   <= 1'b0;
            flush_q      <= 1'b0;
            redir_q      <= 1'b0;
            target_q     <= ced_pkg::VEC_RESET;
            kernel_q     <= 1'b1;
            epc_q        <= '0;
            bd_q         <= 1'b0;
            code_q       <= '0;
            ce_q         <= '0;
            dbg_q        <= '0;
            dbg_tk_q     <= 1'b0;
        end else begin
            nmi_n_prev_q <= nmi_n_prev_d;
            rst_pend_q   <= rst_pend_d;
            nmi_pend_q   <= nmi_pend_d;
            flush_q      <= flush_d;
            redir_q      <= redir_d;
            target_q     <= target_d;
            kernel_q     <= kernel_d;
            epc_q        <= epc_d;
            bd_q         <= bd_d;
            code_q       <= code_d;
            ce_q         <= ce_d;
            dbg_q        <= dbg_d;
            dbg_tk_q     <= dbg_tk_d;
        end
    end

    assign flush             = flush_q;
    assign fetch_redirect    = redir_q;
    assign fetch_target      = target_q;
    assign kernel_mode       = kernel_q;
    assign resume_pc_reg     = epc_q;
    assign delay_slot_flag   = bd_q;
    assign cause_code_field  = code_q;
    assign coproc_error_unit = ce_q;
    assign debug_cause       = dbg_q;
    assign debug_taken       = dbg_tk_q;

    // cause word built from registered fields only
    always_comb begin
        cause_reg = '0;
        cause_reg[ced_pkg::CAUSE_BD_BIT] = bd_q; // [RL4]
        cause_reg[ced_pkg::CAUSE_CE_LO +: 2] = ce_q;
        cause_reg[ced_pkg::CAUSE_CODE_HI:ced_pkg::CAUSE_CODE_LO] = code_q; // [RL5]
    end
endmodule // ced_dispatch

// file: hdl/ced_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module ced_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule // ced_sync

// file: include/ced_pkg.sv
// package of constants for the core exception dispatch block
package ced_pkg;
    localparam int          XLEN               = 32;
    localparam int          CODE_W             = 5;
    localparam int          CP_N               = 4;
    // cause field layout
    localparam int          CAUSE_BD_BIT       = 31;
    localparam int          CAUSE_CE_LO        = 28;
    localparam int          CAUSE_CODE_HI      = 6;
    localparam int          CAUSE_CODE_LO      = 2;
    // cause codes
    localparam logic [4:0]  INT_CODE                = 5'h00;
    localparam logic [4:0]  MAP_MODIFIED_CODE       = 5'h01;
    localparam logic [4:0]  MAP_MISS_LOAD_CODE      = 5'h02;
    localparam logic [4:0]  MAP_MISS_STORE_CODE     = 5'h03;
    localparam logic [4:0]  MISALIGN_LOAD_CODE      = 5'h04;
    localparam logic [4:0]  MISALIGN_STORE_CODE     = 5'h05;
    localparam logic [4:0]  FETCH_BUS_FAULT_CODE    = 5'h06;
    localparam logic [4:0]  DATA_BUS_FAULT_CODE     = 5'h07;
    localparam logic [4:0]  SERVICE_TRAP_CODE       = 5'h08;
    localparam logic [4:0]  TRAP_BREAK_CODE         = 5'h09;
    localparam logic [4:0]  RESERVED_OPCODE_CODE    = 5'h0a;
    localparam logic [4:0]  COPROC_UNUSABLE_CODE    = 5'h0b;
    localparam logic [4:0]  ARITH_OVERFLOW_CODE     = 5'h0c;
    // vectors and delay-slot branch step
    localparam logic [31:0] VEC_RESET          = 32'hbfc0_0000;
    localparam logic [31:0] VEC_USER_MISS      = 32'h8000_0000;
    localparam logic [31:0] VEC_USER_MISS_BOOT = 32'hbfc0_0100;
    localparam logic [31:0] VEC_GENERAL        = 32'h8000_0080;
    localparam logic [31:0] VEC_GENERAL_BOOT   = 32'hbfc0_0180;
    localparam logic [31:0] VEC_DEBUG          = 32'hbfc0_0200;
    localparam logic [31:0] BRANCH_STEP        = 32'h0000_0004;
    // access sizes
    localparam logic [1:0]  SIZE_BYTE          = 2'h0;
    localparam logic [1:0]  SIZE_HALF          = 2'h1;
    localparam logic [1:0]  SIZE_WORD          = 2'h2;
    // exception kinds
    typedef enum logic [2:0] {
        CED_K_NONE    = 3'b000,
        CED_K_RESET   = 3'b001,
        CED_K_NMI     = 3'b010,
        CED_K_DEBUG   = 3'b011,
        CED_K_UMISS   = 3'b100,
        CED_K_GENERAL = 3'b101
    } ced_kind_t;
endpackage

// file: verif/ced_bus_model.sv
// bus interface model that raises a bus fault on request
`timescale 1ns/1ps
module ced_bus_model (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic fault_req,
    input  wire logic flush,
    output logic      bus_error_pin
);
    // fault held until the core flushes, then released low
    always_ff @(posedge clock) begin
        if (!nrst || flush) begin
            bus_error_pin <= 1'b0;
        end else if (fault_req) begin
            bus_error_pin <= 1'b1;
        end
    end
endmodule // ced_bus_model

// file: verif/ced_dispatch_assertions.sv
// concurrent checks on the exception dispatch ports
`timescale 1ns/1ps
module ced_dispatch_chk #(
    parameter int AW = ced_pkg::XLEN
) (
    input wire logic          clock,
    input wire logic          nrst,
    input wire logic          nmi_n_pin,
    input wire logic          bus_error_pin,
    input wire logic          stage_valid,
    input wire logic [AW-1:0] stage_pc,
    input wire logic          stage_in_delay_slot,
    input wire logic          service_trap_instr,
    input wire logic          user_map_miss,
    input wire logic          debug_step,
    input wire logic          debug_break,
    input wire logic          boot_vector_select,
    input wire logic          flush,
    input wire logic          fetch_redirect,
    input wire logic [AW-1:0] fetch_target,
    input wire logic          kernel_mode,
    input wire logic [AW-1:0] resume_pc_reg,
    input wire logic          delay_slot_flag,
    input wire logic [4:0]    cause_code_field,
    input wire logic [31:0]   cause_reg,
    input wire logic          debug_taken
);
    logic [3:0] nmi_h_q;
    logic [3:0] be_h_q;
    logic       calm;
    // no pin event can be pending in the synchronisers
    always_ff @(posedge clock) begin
        nmi_h_q <= {nmi_h_q[2:0], nmi_n_pin};
        be_h_q  <= {be_h_q[2:0], bus_error_pin};
    end
    assign calm = (&nmi_h_q) & nmi_n_pin & ~(|be_h_q) & ~bus_error_pin;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_kernel_entry: assert property (flush |-> kernel_mode) else $error("kernel mode missing on entry");
    a_redirect_pair: assert property (flush |-> fetch_redirect) else $error("flush without redirect");
    a_reset_vector: assert property ($rose(nrst) |=> flush && fetch_target == 32'hbfc0_0000)
        else $error("reset exception not taken");
    a_nmi_vector: assert property ($fell(nmi_n_pin) |-> ##[1:6] flush && fetch_target == 32'hbfc0_0000)
        else $error("nmi not taken");
    a_slot_resume: assert property (stage_valid && calm && $past(nrst) && service_trap_instr
        && stage_in_delay_slot |=> resume_pc_reg == $past(stage_pc) - 32'h4 && delay_slot_flag)
        else $error("delay slot resume wrong");
    a_plain_resume: assert property (stage_valid && calm && $past(nrst) && service_trap_instr
        && !stage_in_delay_slot |=> resume_pc_reg == $past(stage_pc) && !delay_slot_flag)
        else $error("plain resume wrong");
    a_cause_layout: assert property (cause_reg[31] == delay_slot_flag
        && cause_reg[6:2] == cause_code_field) else $error("cause layout wrong");
    a_no_modified: assert property (cause_code_field != 5'h01) else $error("map modified code seen");
    a_debug_vector: assert property (stage_valid && calm && $past(nrst) && (debug_step || debug_break)
        |=> debug_taken && fetch_target == 32'hbfc0_0200) else $error("debug vector wrong");
    a_general_vector: assert property (stage_valid && calm && $past(nrst) && service_trap_instr
        && !debug_step && !debug_break && !user_map_miss
        |=> fetch_target == ($past(boot_vector_select) ? 32'hbfc0_0180 : 32'h8000_0080))
        else $error("general vector wrong");
    c_debug: cover property (debug_taken);
    c_slot: cover property (flush && delay_slot_flag);
    c_boot: cover property (flush && boot_vector_select);
endmodule // ced_dispatch_chk
bind ced_dispatch ced_dispatch_chk #(.AW(AW)) chk_u (
    .clock(clock), .nrst(nrst), .nmi_n_pin(nmi_n_pin), .bus_error_pin(bus_error_pin),
    .stage_valid(stage_valid), .stage_pc(stage_pc), .stage_in_delay_slot(stage_in_delay_slot),
    .service_trap_instr(service_trap_instr), .user_map_miss(user_map_miss), .debug_step(debug_step),
    .debug_break(debug_break), .boot_vector_select(boot_vector_select), .flush(flush),
    .fetch_redirect(fetch_redirect), .fetch_target(fetch_target), .kernel_mode(kernel_mode),
    .resume_pc_reg(resume_pc_reg), .delay_slot_flag(delay_slot_flag), .cause_code_field(cause_code_field),
    .cause_reg(cause_reg), .debug_taken(debug_taken)
);

// file: verif/ced_dispatch_tb.sv
// self-checking bench for the exception dispatch block
`timescale 1ns/1ps
module ced_dispatch_tb;
    logic        clock, nrst, nmi_n_pin, bus_error_pin, fault_req, stage_valid, stage_in_delay_slot;
    logic        stage_is_fetch_fault, mem_access, mem_store, fetch_misaligned, trap_overflow;
    logic        service_trap_instr, break_instr, reserved_opcode, coproc_instr, irq_pending, protect_req;
    logic        user_map_miss, debug_step, debug_break, return_from_exc, boot_vector_select;
    logic        flush, fetch_redirect, kernel_mode, delay_slot_flag, debug_taken;
    logic [1:0]  mem_size, coproc_unit, coproc_error_unit, debug_cause;
    logic [3:0]  coproc_usable_bits;
    logic [4:0]  cause_code_field;
    logic [31:0] stage_pc, mem_addr, fetch_target, resume_pc_reg, cause_reg;
    int          error_cnt = 0;
    int          num_checks = 0;
    ced_dispatch dut_u (
        .clock(clock), .nrst(nrst), .nmi_n_pin(nmi_n_pin), .bus_error_pin(bus_error_pin),
        .stage_valid(stage_valid), .stage_pc(stage_pc), .stage_in_delay_slot(stage_in_delay_slot),
        .stage_is_fetch_fault(stage_is_fetch_fault), .mem_access(mem_access), .mem_store(mem_store),
        .mem_size(mem_size), .mem_addr(mem_addr), .fetch_misaligned(fetch_misaligned),
        .trap_overflow(trap_overflow), .service_trap_instr(service_trap_instr), .break_instr(break_instr),
        .reserved_opcode(reserved_opcode), .coproc_instr(coproc_instr), .coproc_unit(coproc_unit),
        .irq_pending(irq_pending), .protect_req(protect_req), .user_map_miss(user_map_miss),
        .debug_step(debug_step), .debug_break(debug_break), .return_from_exc(return_from_exc),
        .boot_vector_select(boot_vector_select), .coproc_usable_bits(coproc_usable_bits),
        .flush(flush), .fetch_redirect(fetch_redirect), .fetch_target(fetch_target),
        .kernel_mode(kernel_mode), .resume_pc_reg(resume_pc_reg), .delay_slot_flag(delay_slot_flag),
        .cause_code_field(cause_code_field), .coproc_error_unit(coproc_error_unit), .cause_reg(cause_reg),
        .debug_cause(debug_cause), .debug_taken(debug_taken)
    );
    ced_bus_model bus_u (.clock(clock), .nrst(nrst), .fault_req(fault_req), .flush(flush),
                         .bus_error_pin(bus_error_pin));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic idle();
        {stage_valid, stage_in_delay_slot, stage_is_fetch_fault, mem_access, mem_store, fetch_misaligned} = '0;
        {trap_overflow, service_trap_instr, break_instr, reserved_opcode, coproc_instr, irq_pending} = '0;
        {protect_req, user_map_miss, debug_step, debug_break, return_from_exc, fault_req} = '0;
        mem_size = 2'h0;
        mem_addr = 32'h0000_2000;
        coproc_unit = 2'h2;
    endtask
    // conditions already set; one cycle of stage_valid, outputs visible on return
    task automatic take();
        repeat (3) @(negedge clock);
        stage_valid = 1'b1;
        @(negedge clock);
        idle();
        chk("entry", {flush, fetch_redirect, kernel_mode}, 3'b111);
    endtask
    task automatic t_codes(input logic bv);
        logic [4:0] exp [10] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0a, 5'h0b, 5'h08, 5'h09, 5'h0c};
        boot_vector_select = bv;
        for (int i = 0; i < 10; i++) begin
            case (i)
                0: irq_pending = 1'b1;
                1, 2: protect_req = 1'b1;
                5: reserved_opcode = 1'b1;
                6: coproc_instr = 1'b1;
                7: service_trap_instr = 1'b1;
                8: break_instr = 1'b1;
                9: trap_overflow = 1'b1;
                3: {mem_size, mem_addr} = {2'h2, 32'h0000_2002};
                default: {mem_size, mem_addr} = {2'h1, 32'h0000_2001};
            endcase
            mem_access = (i > 0 && i < 5);
            mem_store = (i == 2 || i == 4);
            take();
            chk("code", cause_code_field, exp[i]);
            chk("vector", fetch_target, bv ? 32'hbfc0_0180 : 32'h8000_0080);
            if (i == 6) chk("unit", cause_reg[29:28], 2'h2);
            if (i == 6) chk("ce_out", coproc_error_unit, 2'h2);
        end
    endtask
    task automatic t_slot();
        for (int d = 0; d < 2; d++) begin
            service_trap_instr = 1'b1;
            stage_in_delay_slot = d[0];
            take();
            chk("resume", resume_pc_reg, d ? 32'h0000_0ffc : 32'h0000_1000);
            chk("slot", {delay_slot_flag, cause_reg[31]}, {2{d[0]}});
        end
    endtask
    task automatic t_bus();
        for (int f = 0; f < 2; f++) begin
            repeat (4) @(negedge clock);
            {stage_is_fetch_fault, fault_req, stage_valid} = {f[0], 2'b11};
            for (int n = 0; n < 10 && flush !== 1'b1; n++) @(negedge clock);
            idle();
            chk("bus", {flush, cause_code_field}, {1'b1, f ? 5'h06 : 5'h07});
        end
    endtask
    task automatic t_fixed();
        for (int b = 0; b < 2; b++) begin
            boot_vector_select = b[0];
            user_map_miss = 1'b1;
            take();
            chk("umiss", fetch_target, b ? 32'hbfc0_0100 : 32'h8000_0000);
            chk("umiss_code", cause_code_field, 5'h02);
            debug_break = b[0];
            debug_step = !b[0];
            take();
            chk("dbg", {debug_taken, debug_cause}, {1'b1, b ? 2'h2 : 2'h1});
            chk("dbg_vec", fetch_target, 32'hbfc0_0200);
            chk("dbg_code", cause_code_field, 5'h02);
        end
    endtask
    task automatic t_user_nmi();
        {fetch_misaligned, mem_access, mem_store} = 3'b111;
        take();
        chk("fetch_align", cause_code_field, 5'h04);
        return_from_exc = 1'b1;
        @(negedge clock);
        return_from_exc = 1'b0;
        @(negedge clock);
        chk("user", kernel_mode, 1'b0);
        {mem_access, mem_addr} = {1'b1, 32'h8000_0000};
        take();
        chk("kseg", cause_code_field, 5'h04);
        repeat (3) @(negedge clock);
        nmi_n_pin = 1'b0;
        for (int n = 0; n < 8 && flush !== 1'b1; n++) @(negedge clock);
        chk("nmi", flush, 1'b1);
        chk("nmi_vec", fetch_target, 32'hbfc0_0000);
        chk("nmi_code", cause_code_field, 5'h04);
        nmi_n_pin = 1'b1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        final_report();
    end
    initial begin
        {nrst, nmi_n_pin, boot_vector_select} = 3'b010;
        coproc_usable_bits = 4'hb;
        stage_pc = 32'h0000_1000;
        idle();
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        chk("reset", {flush, kernel_mode}, 2'b11);
        chk("reset_vec", fetch_target, 32'hbfc0_0000);
        @(negedge clock);
        chk("reset_once", flush, 1'b0);
        t_codes(1'b0);
        t_codes(1'b1);
        t_slot();
        t_bus();
        t_fixed();
        t_user_nmi();
        final_report();
    end
endmodule // ced_dispatch_tb
